// File: rtl/wdc_top.sv
// How it works
// - counter runs off low power rc tick
// - prescaler divides by 32 or 128
// - postscaler gives sixteen ratios up to 32768
// - finished clock switch clears all counts
// - power save entry and exit clear counts
// - clear instruction restarts counts before timeout
// - keeps counting asleep; timeout wakes device
// - hardware enable forces watchdog always on
// - otherwise software enable bit gates it
// - software enable cleared on every reset
// - timeout flag sticks until software clears
// - window disable low enables windowed clearing
// - reset reloads configuration from top flash
// - erasing last page erases config, protects
// - config bits 23:10 and bit 5 have no effect
// - rc clock stays on in sleep while enabled
`timescale 1ns/10ps
`default_nettype none

module wdc_top (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        clear_instr,     // watchdog clear instruction
   input  wire logic        pwrsave_sleep,   // power save into sleep
   input  wire logic        pwrsave_idle,    // power save into idle
   input  wire logic        wake_event,      // other wake source
   input  wire logic        clk_switch_done, // clock switch completed
   input  wire logic        sw_enable_set,   // software enable write 1
   input  wire logic        sw_enable_clr,   // software enable write 0
   input  wire logic        timeout_clr,     // software clears flag
   input  wire logic [23:0] flash_cfg_word,  // top of flash config
   input  wire logic        last_page_erase, // last page erased
   output logic             low_power_rc_clock_enable,
   output logic             wdt_running,
   output logic             wake_out,
   output logic             reset_req,
   output logic             timeout_flag,
   output logic             software_enable_bit,
   output logic             code_protect,
   output logic [23:0]      cfg_shadow,
   output logic [14:0]      postscale_count
);

   wdc_cnt_if cnt ();

   logic [23:0]              cfg_q, cfg_d;
   logic                     load_q, load_d;
   logic                     prot_q, prot_d;
   logic                     swen_q, swen_d;
   logic                     flag_q, flag_d;
   logic                     rst_q, rst_d;
   logic                     wake_q, wake_d;
   logic                     en_q, en_d;
   logic [14:0]              post_q;
   logic [9:0]               div_q, div_d;
   logic                     tick_q, tick_d;
   wdc_pkg::wdc_pwr_type     pwr_q, pwr_d;
   logic                     enabled;
   logic                     win_open;
   logic                     early_clr;
   logic                     leave_save;
   logic [22:0]              elapsed;
   logic [22:0]              period;

   // ---------------------------------------------------------------
   // configuration shadow and enable
   // ---------------------------------------------------------------
   always_comb begin
      cfg_d  = cfg_q;
      load_d = 1'b0;
      prot_d = prot_q;
      if (load_q) begin
         cfg_d  = flash_cfg_word & wdc_pkg::CFG_LIVE;
         prot_d = 1'b0;
      end
      if (last_page_erase) begin
         cfg_d  = wdc_pkg::CFG_ERASED;
         prot_d = 1'b1;
      end
      swen_d = swen_q;
      if (sw_enable_set)
         swen_d = 1'b1;
      else if (sw_enable_clr)
         swen_d = 1'b0;
      enabled = cfg_q[wdc_pkg::HWEN_BIT] | swen_q;
      en_d    = enabled;
   end

   // ---------------------------------------------------------------
   // config registers; load runs one cycle after reset release
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_q  <= wdc_pkg::CFG_RST;
         load_q <= 1'b1;
         prot_q <= 1'b0;
         swen_q <= 1'b0;
         en_q   <= 1'b0;
      end else begin
         cfg_q  <= cfg_d;
         load_q <= load_d;
         prot_q <= prot_d;
         swen_q <= swen_d;
         en_q   <= en_d;
      end
   end

   // ---------------------------------------------------------------
   // low power rc tick divider
   // ---------------------------------------------------------------
   always_comb begin
      div_d  = div_q;
      tick_d = 1'b0;
      if (!enabled) begin
         div_d = 10'h000;
      end else if (div_q == wdc_pkg::LOW_POWER_RC_CLOCK_DIV_M1) begin
         div_d  = 10'h000;
         tick_d = 1'b1;
      end else begin
         div_d = 10'(div_q + 10'h001);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_q  <= 10'h000;
         tick_q <= 1'b0;
      end else begin
         div_q  <= div_d;
         tick_q <= tick_d;
      end
   end

   // ---------------------------------------------------------------
   // power state, window check, clears
   // ---------------------------------------------------------------
   always_comb begin
      pwr_d      = pwr_q;
      leave_save = 1'b0;
      unique case (pwr_q)
         wdc_pkg::WDC_RUN: begin
            if (pwrsave_sleep)
               pwr_d = wdc_pkg::WDC_SLEEP;
            else if (pwrsave_idle)
               pwr_d = wdc_pkg::WDC_IDLE;
         end
         wdc_pkg::WDC_SLEEP, wdc_pkg::WDC_IDLE: begin
            if (wake_event || (cnt.expire && enabled)) begin
               pwr_d      = wdc_pkg::WDC_RUN;
               leave_save = 1'b1;
            end
         end
         default: pwr_d = wdc_pkg::WDC_RUN;
      endcase
      // ticks since the last clear against the whole period, so the
      // window also works with a one to one postscaler
      elapsed = cfg_q[wdc_pkg::PRESEL_BIT]
                ? {1'h0, cnt.post_cnt, cnt.pre_cnt}
                : {3'h0, cnt.post_cnt, cnt.pre_cnt[4:0]};
      period  = 23'h000001 << ({1'h0, cfg_q[wdc_pkg::POST_LSB +: 4]}
                + (cfg_q[wdc_pkg::PRESEL_BIT] ? 5'h07 : 5'h05));
      unique case (cfg_q[wdc_pkg::WINSEL_LSB +: 2])
         2'h0:    win_open = elapsed >= 23'(period - (period >> 2));
         2'h1:    win_open = elapsed >= (period >> 1);
         2'h2:    win_open = elapsed >= (period >> 2);
         default: win_open = elapsed >= (period >> 3);
      endcase
      early_clr = clear_instr && enabled && (pwr_q == wdc_pkg::WDC_RUN)
                  && !cfg_q[wdc_pkg::WINDOW_DISABLE_BIT_BIT] && !win_open;
      cnt.clear = !enabled || clk_switch_done
                  || ((pwrsave_sleep || pwrsave_idle)
                      && pwr_q == wdc_pkg::WDC_RUN)
                  || leave_save
                  || (clear_instr && pwr_q == wdc_pkg::WDC_RUN);
      cnt.tick     = tick_q;
      cnt.pre_long = cfg_q[wdc_pkg::PRESEL_BIT];
      cnt.ratio    = cfg_q[wdc_pkg::POST_LSB +: 4];
      // timeout flag: set wins over software clear
      flag_d = (flag_q && !timeout_clr) || (cnt.expire && enabled);
      rst_d  = (cnt.expire && enabled && pwr_q == wdc_pkg::WDC_RUN)
               || early_clr;
      wake_d = leave_save && !wake_event;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pwr_q  <= wdc_pkg::WDC_RUN;
         flag_q <= 1'b0;
         rst_q  <= 1'b0;
         wake_q <= 1'b0;
         post_q <= wdc_pkg::POST_RST;
      end else begin
         pwr_q  <= pwr_d;
         flag_q <= flag_d;
         rst_q  <= rst_d;
         wake_q <= wake_d;
         post_q <= cnt.post_cnt;
      end
   end

   // ---------------------------------------------------------------
   // divider chain
   // ---------------------------------------------------------------
   wdc_chain u_chain (
      .clk   (clk),
      .rst_b (rst_b),
      .cnt   (cnt)
   );

   // ---------------------------------------------------------------
   // outputs, all from flip-flops
   // ---------------------------------------------------------------
   assign low_power_rc_clock_enable         = en_q;
   assign wdt_running         = en_q;
   assign wake_out            = wake_q;
   assign reset_req           = rst_q;
   assign timeout_flag        = flag_q;
   assign software_enable_bit = swen_q;
   assign code_protect        = prot_q;
   assign cfg_shadow          = cfg_q;
   assign postscale_count     = post_q;

endmodule : wdc_top

`default_nettype wire

// File: rtl/wdc_pkg.sv
package wdc_pkg;

   // ---------------------------------------------------------------
   // clock and rates
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ      = 20_000_000;
   localparam int unsigned LOW_POWER_RC_CLOCK_HZ     = 32_000;
   // system clocks per low power rc tick, rounded down
   localparam int unsigned LOW_POWER_RC_CLOCK_DIV    = CLK_HZ / LOW_POWER_RC_CLOCK_HZ;
   localparam logic [9:0]  LOW_POWER_RC_CLOCK_DIV_M1 = 10'(LOW_POWER_RC_CLOCK_DIV - 1);

   // ---------------------------------------------------------------
   // prescaler and postscaler
   // ---------------------------------------------------------------
   localparam logic [6:0]  PRE_SHORT_M1 = 7'h1F;  // divide by 32
   localparam logic [6:0]  PRE_LONG_M1  = 7'h7F;  // divide by 128
   localparam int unsigned POST_W       = 15;
   localparam logic [14:0] POST_RST     = 15'h0000;

   // ---------------------------------------------------------------
   // configuration word layout
   // ---------------------------------------------------------------
   localparam int unsigned CFG_W       = 24;
   localparam int unsigned POST_LSB    = 0;   // postscale ratio 3:0
   localparam int unsigned PRESEL_BIT  = 4;
   localparam int unsigned HWEN_BIT    = 7;
   localparam int unsigned WINDOW_DISABLE_BIT_BIT  = 6;
   localparam int unsigned WINSEL_LSB  = 8;   // window select 9:8
   localparam logic [23:0] CFG_RST     = 24'h000000;
   localparam logic [23:0] CFG_LIVE    = 24'h0003DF; // implemented bits
   localparam logic [23:0] CFG_ERASED  = 24'h000000; // erased page value
   localparam logic [7:0]  PROT_RST    = 8'h00;

   // ---------------------------------------------------------------
   // power states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      WDC_RUN   = 3'b001,
      WDC_SLEEP = 3'b010,
      WDC_IDLE  = 3'b100
   } wdc_pwr_type;

endpackage : wdc_pkg

// File: rtl/wdc_cnt_if.sv
`timescale 1ns/10ps
`default_nettype none

// counter controls from the top to the divider chain
interface wdc_cnt_if;
   logic        tick;      // one low power rc tick
   logic        clear;     // clear prescaler and postscaler
   logic        pre_long;  // divide by 128 when high
   logic [3:0]  ratio;     // postscale ratio selector
   logic [14:0] post_cnt;  // postscaler count
   logic [6:0]  pre_cnt;   // prescaler count
   logic        expire;    // one cycle timeout pulse

   modport top (output tick, clear, pre_long, ratio,
                input post_cnt, pre_cnt, expire);
   modport chain (input tick, clear, pre_long, ratio,
                  output post_cnt, pre_cnt, expire);
endinterface : wdc_cnt_if

`default_nettype wire

// File: rtl/wdc_chain.sv
`timescale 1ns/10ps
`default_nettype none

// prescaler followed by a selectable postscaler
module wdc_chain (
   input  wire logic clk,
   input  wire logic rst_b,
   wdc_cnt_if.chain  cnt
);

   logic [6:0]  pre_q,  pre_d;
   logic [14:0] post_q, post_d;
   logic        exp_q,  exp_d;
   logic        pre_end;
   logic [14:0] post_top;

   // ---------------------------------------------------------------
   // next count
   // ---------------------------------------------------------------
   always_comb begin
      pre_end  = cnt.pre_long ? (pre_q == wdc_pkg::PRE_LONG_M1)
                              : (pre_q == wdc_pkg::PRE_SHORT_M1);
      post_top = 15'((16'h0001 << cnt.ratio) - 16'h0001);
      pre_d    = pre_q;
      post_d   = post_q;
      exp_d    = 1'b0;
      if (cnt.clear) begin
         pre_d  = '0;
         post_d = wdc_pkg::POST_RST;
      end else if (cnt.tick) begin
         pre_d = pre_end ? 7'h00 : 7'(pre_q + 7'h01);
         if (pre_end) begin
            if (post_q >= post_top) begin
               post_d = wdc_pkg::POST_RST;
               exp_d  = 1'b1;
            end else begin
               post_d = 15'(post_q + 15'h0001);
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // count registers, cleared by any reset
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pre_q  <= 7'h00;
         post_q <= wdc_pkg::POST_RST;
         exp_q  <= 1'b0;
      end else begin
         pre_q  <= pre_d;
         post_q <= post_d;
         exp_q  <= exp_d;
      end
   end

   assign cnt.post_cnt = post_q;
   assign cnt.pre_cnt  = pre_q;
   assign cnt.expire   = exp_q;

endmodule : wdc_chain

`default_nettype wire

// File: testbench/wdc_chk_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ------
// watchdog port checker
// ------
module wdc_chk (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        clear_instr,
   input wire logic        pwrsave_sleep,
   input wire logic        pwrsave_idle,
   input wire logic        clk_switch_done,
   input wire logic        timeout_clr,
   input wire logic        low_power_rc_clock_enable,
   input wire logic        wdt_running,
   input wire logic        wake_out,
   input wire logic        reset_req,
   input wire logic        timeout_flag,
   input wire logic        software_enable_bit,
   input wire logic [23:0] cfg_shadow,
   input wire logic [14:0] postscale_count
);
   logic [15:0] quiet_q;
   logic [15:0] quiet_d;
   logic        kick;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // cycles since the counts were last restarted, saturating
   assign kick = clear_instr | pwrsave_sleep | pwrsave_idle | clk_switch_done
                 | !wdt_running | reset_req | wake_out;
   always_comb begin
      if (kick) quiet_d = 16'h0000;
      else if (quiet_q == 16'hFFFF) quiet_d = quiet_q;
      else quiet_d = quiet_q + 16'h0001;
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) quiet_q <= 16'h0000;
      else quiet_q <= quiet_d;
   end
   // assertions
   a_low_power_rc_clock_follows: assert property (low_power_rc_clock_enable
      == ($past(cfg_shadow[7]) || $past(software_enable_bit)))
      else $error("rc clock enable differs from watchdog enable");
   a_clear_restarts: assert property (clear_instr
      |-> ##2 postscale_count == 15'h0000)
      else $error("clear did not restart counts");
   a_hw_forces_on: assert property (cfg_shadow[7] && $past(cfg_shadow[7])
      |-> wdt_running) else $error("hardware enable did not run");
   a_sw_gates: assert property (!cfg_shadow[7] && !$past(cfg_shadow[7])
      |-> wdt_running == $past(software_enable_bit))
      else $error("software enable does not gate watchdog");
   a_flag_sticky: assert property (timeout_flag && !timeout_clr
      |=> timeout_flag) else $error("timeout flag dropped");
   a_wake_flags: assert property (wake_out |-> ##[0:1] timeout_flag)
      else $error("wake without timeout flag");
   a_reset_pulse: assert property (reset_req |=> !reset_req)
      else $error("reset request longer than one cycle");
   a_wake_pulse: assert property (wake_out |=> !wake_out)
      else $error("wake longer than one cycle");
   a_event_clears: assert property (pwrsave_sleep || pwrsave_idle
      || clk_switch_done |-> ##2 postscale_count == 15'h0000)
      else $error("counts not cleared");
   a_upper_idle: assert property (cfg_shadow[23:10] == 14'h0000
      && !cfg_shadow[5]) else $error("unimplemented config bits set");
   a_no_early_out: assert property ((reset_req || wake_out)
      && cfg_shadow[6] |-> quiet_q >= 16'd19000)
      else $error("timeout too early");
   a_timeout_due: assert property (wdt_running
      && cfg_shadow[4:0] == 5'h00 |-> quiet_q < 16'd21000)
      else $error("timeout missing");
   a_early_clear: assert property (clear_instr && wdt_running
      && !cfg_shadow[6] && !cfg_shadow[4] && quiet_q < 16'd1500
      |=> reset_req) else $error("early clear not punished");
   c_reset: cover property (reset_req);
   c_wake: cover property (wake_out);
   c_window: cover property (clear_instr && !cfg_shadow[6]);
endmodule : wdc_chk

bind wdc_top wdc_chk wdc_chk_i (.clk(clk), .rst_b(rst_b),
   .clear_instr(clear_instr), .pwrsave_sleep(pwrsave_sleep),
   .pwrsave_idle(pwrsave_idle), .clk_switch_done(clk_switch_done),
   .timeout_clr(timeout_clr), .low_power_rc_clock_enable(low_power_rc_clock_enable),
   .wdt_running(wdt_running), .wake_out(wake_out), .reset_req(reset_req),
   .timeout_flag(timeout_flag), .software_enable_bit(software_enable_bit),
   .cfg_shadow(cfg_shadow), .postscale_count(postscale_count));
`default_nettype wire

// File: testbench/wdc_core.sv
`timescale 1ns/10ps
`default_nettype none
// ------
// processor core issuing watchdog instructions
// ------
module wdc_core (
   input  wire logic clk,
   input  wire logic wake_out,
   output logic      clear_instr,
   output logic      pwrsave_sleep,
   output logic      pwrsave_idle,
   output logic      wake_event,
   output logic      clk_switch_done,
   output logic      sw_enable_set,
   output logic      sw_enable_clr,
   output logic      timeout_clr,
   output logic      last_page_erase
);
   logic [8:0] pulse_q  = 9'h000;
   logic       asleep_q = 1'b0;  // sleep or idle status flag
   // one line per instruction
   assign clear_instr     = pulse_q[0];
   assign pwrsave_sleep   = pulse_q[1];
   assign pwrsave_idle    = pulse_q[2];
   assign wake_event      = pulse_q[3];
   assign clk_switch_done = pulse_q[4];
   assign sw_enable_set   = pulse_q[5];
   assign sw_enable_clr   = pulse_q[6];
   assign timeout_clr     = pulse_q[7];
   assign last_page_erase = pulse_q[8];
   // raise one line for one clock, changed just after an edge
   task issue(input int k);
      pulse_q = 9'h001 << k;
      @(posedge clk);
      #5;
      pulse_q = 9'h000;
   endtask : issue
   // software drops its status flag after a watchdog wake
   always @(posedge clk) begin
      if (pulse_q[1] || pulse_q[2]) asleep_q <= 1'b1;
      else if (wake_out === 1'b1) asleep_q <= 1'b0;
   end
endmodule : wdc_core
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// ------
// watchdog testbench
// ------
module testbench;
   logic        clk, rst_b, clear_instr, pwrsave_sleep, pwrsave_idle;
   logic        wake_event, clk_switch_done, sw_enable_set, sw_enable_clr;
   logic        timeout_clr, last_page_erase, low_power_rc_clock_enable, wdt_running;
   logic        wake_out, reset_req, timeout_flag, software_enable_bit;
   logic        code_protect;
   logic [23:0] flash_cfg_word;
   logic [23:0] cfg_shadow;
   logic [14:0] postscale_count;
   int          bad_count;
   int          checked;
   int          rr_cnt;
   int          wk_cnt;
   int          base;
   int          base2;
   int          i;
   int          k;

   wdc_top wdc_top_i (.clk(clk), .rst_b(rst_b), .clear_instr(clear_instr),
      .pwrsave_sleep(pwrsave_sleep), .pwrsave_idle(pwrsave_idle),
      .wake_event(wake_event), .clk_switch_done(clk_switch_done),
      .sw_enable_set(sw_enable_set), .sw_enable_clr(sw_enable_clr),
      .timeout_clr(timeout_clr), .flash_cfg_word(flash_cfg_word),
      .last_page_erase(last_page_erase), .low_power_rc_clock_enable(low_power_rc_clock_enable),
      .wdt_running(wdt_running), .wake_out(wake_out), .reset_req(reset_req),
      .timeout_flag(timeout_flag), .software_enable_bit(software_enable_bit),
      .code_protect(code_protect), .cfg_shadow(cfg_shadow),
      .postscale_count(postscale_count));
   wdc_core wdc_core_i (.clk(clk), .wake_out(wake_out),
      .clear_instr(clear_instr), .pwrsave_sleep(pwrsave_sleep),
      .pwrsave_idle(pwrsave_idle), .wake_event(wake_event),
      .clk_switch_done(clk_switch_done), .sw_enable_set(sw_enable_set),
      .sw_enable_clr(sw_enable_clr), .timeout_clr(timeout_clr),
      .last_page_erase(last_page_erase));

   // 20 MHz clock and pulse counters sampled mid-cycle
   initial clk = 1'b0;
   always #25 clk = ~clk;
   always @(negedge clk) begin
      if (reset_req === 1'b1) rr_cnt++;
      if (wake_out === 1'b1) wk_cnt++;
   end

   task cyc(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask : cyc

   task check(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task do_reset(input logic [23:0] cfg);
      rst_b = 1'b0;
      flash_cfg_word = cfg;
      cyc(12);
      rst_b = 1'b1;
      cyc(3);
   endtask : do_reset

   // wait a bounded time for a reset request or wake pulse
   task await(input int n);
      int b;
      b = rr_cnt + wk_cnt;
      for (i = 0; i < n && rr_cnt + wk_cnt == b; i++) cyc(1);
   endtask : await

   task final_report;
      if (bad_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report

   // main sequence
   initial begin
      rst_b = 1'b0;
      flash_cfg_word = 24'h000000;
      do_reset(24'hFFFFE0);
      check(cfg_shadow, 24'h0003C0);
      check(low_power_rc_clock_enable, 24'h1);
      wdc_core_i.issue(6);
      cyc(3);
      check(wdt_running, 24'h1);
      for (k = 0; k < 2; k++) begin
         cyc(1000);
         wdc_core_i.issue(k == 0 ? 0 : 4);
         base = rr_cnt;
         cyc(19000);
         check(rr_cnt - base, 24'h0);
         await(2000);
         check(rr_cnt - base, 24'h1);
         check(timeout_flag, 24'h1);
      end
      wdc_core_i.issue(7);
      cyc(2);
      check(timeout_flag, 24'h0);
      cyc(1000);
      wdc_core_i.issue(1);
      base = wk_cnt;
      base2 = rr_cnt;
      cyc(19000);
      check(wk_cnt - base, 24'h0);
      await(2000);
      check(wk_cnt - base, 24'h1);
      check(rr_cnt - base2, 24'h0);
      check(low_power_rc_clock_enable, 24'h1);
      check(timeout_flag, 24'h1);
      check(wdc_core_i.asleep_q, 24'h0);
      // idle left by another wake source gives no watchdog wake
      base = wk_cnt;
      base2 = rr_cnt;
      wdc_core_i.issue(2);
      cyc(2);
      wdc_core_i.issue(3);
      cyc(3);
      check(wk_cnt - base + rr_cnt - base2, 24'h0);
      // windowed mode, postscale 1:2, window opens at half period
      do_reset(24'hFFFD81);
      check(cfg_shadow, 24'h000181);
      cyc(20100);
      check(postscale_count, 24'h1);
      base = rr_cnt;
      wdc_core_i.issue(0);
      cyc(3);
      check(rr_cnt - base, 24'h0);
      check(postscale_count, 24'h0);
      cyc(100);
      wdc_core_i.issue(0);
      cyc(3);
      check(rr_cnt - base, 24'h1);
      do_reset(24'h000000);
      check(wdt_running, 24'h0);
      wdc_core_i.issue(5);
      cyc(3);
      check(software_enable_bit, 24'h1);
      check(wdt_running, 24'h1);
      do_reset(24'h000000);
      check(software_enable_bit, 24'h0);
      check(postscale_count, 24'h0);
      wdc_core_i.issue(8);
      cyc(2);
      check(code_protect, 24'h1);
      final_report;
   end

   // hang guard, well beyond the expected run length
   initial begin
      cyc(95000);
      bad_count++;
      final_report;
   end
endmodule : testbench
`default_nettype wire
